// file: core/jtx_dll.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
module jtx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk_i)
  begin
    if (in_valid_i && !full)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (in_valid_i && !full)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready_i && !empty)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule // jtx_fifo

////////////////////////////////////////////////////////////////////////////
module jtx_dll import jtx_pkg::*; #(
  parameter logic [7:0] DEV_ID = 8'h5A,
  parameter logic [3:0] BANK_ID = 4'h0,
  parameter logic [2:0] SUBCLASS = 3'h1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [SAMPLE_W-1:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic link_sync_request_n_i,
  input wire logic system_timing_reference_i,
  input wire logic timing_ref_enable_i,
  input wire logic scramble_en_i,
  input wire logic align_insert_en_i,
  input wire logic lane_invert_i,
  input wire logic offset_binary_i,
  input wire logic [4:0] lanes_m1_i,
  input wire logic [4:0] lane_id_i,
  input wire logic [7:0] octets_per_frame_m1_i,
  input wire logic [4:0] frames_per_mf_m1_i,
  output logic [9:0] symbol_o,
  output logic ilas_active_o,
  output logic user_data_o
);

  // Scrambles one octet MSB first, returns {state, octet}
  function automatic logic [22:0] scr8(input logic [7:0] d,
                                       input logic [14:0] st);
    logic [14:0] s;
    logic [7:0] o;
    s = st;
    o = '0;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ s[SCR_TAP_A] ^ s[SCR_TAP_B];
      s = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction

  // Returns {disparity after, abcdei, fghj}; rd high means positive
  function automatic logic [10:0] enc(input logic [7:0] d, input logic k,
                                     input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic u6;
    logic u4;
    logic rd6;
    logic alt;
    s6 = k ? K28_6B : ENC6_NEG[d[4:0]];
    u6 = ($countones(s6) != 3);
    if (rd && (u6 || d[4:0] == 5'h07))
    begin
      s6 = ~s6;
    end
    rd6 = rd ^ u6;
    alt = (d[7:5] == 3'h7) && (k ||
          (!rd6 && (d[4:0] == 5'h11 || d[4:0] == 5'h12 ||
                    d[4:0] == 5'h14)) ||
          (rd6 && (d[4:0] == 5'h0B || d[4:0] == 5'h0D ||
                   d[4:0] == 5'h0E)));
    s4 = alt ? ENC4_ALT : ENC4_NEG[d[7:5]];
    u4 = ($countones(s4) != 2);
    // K28 flips its balanced tails when the 6b half left disparity negative
    if ((rd6 && (u4 || d[7:5] == 3'h3)) ||
        (k && !rd6 && !u4 && d[7:5] != 3'h3))
    begin
      s4 = ~s4;
    end
    return {rd6 ^ u4, s6, s4};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  jtx_state_type state_reg;
  logic sync_s1_reg;
  logic sync_s2_reg;
  logic sref_s1_reg;
  logic sref_s2_reg;
  logic sref_d_reg;
  logic [7:0] oct_reg;
  logic [4:0] frm_reg;
  logic [12:0] mpos_reg;
  logic [1:0] mf_idx_reg;
  logic [7:0] ramp_reg;
  logic lo_phase_reg;
  logic [7:0] lo_reg;
  logic [7:0] last_reg;
  logic [14:0] scr_reg;
  logic rd_reg;
  logic sref_edge;
  logic frame_end;
  logic mf_end;
  logic fifo_valid;
  logic [SAMPLE_W-1:0] fifo_data;
  logic [SAMPLE_W-1:0] fmt_sample;
  logic take_sample;
  logic [7:0] raw_oct;
  logic [22:0] scr_word;
  logic [7:0] data_oct;
  logic [7:0] oct_sel;
  logic k_sel;
  logic ramp_slot;
  logic [10:0] enc_word;
  logic [7:0] cfg [0:CFG_COUNT-1];
  logic [3:0] cfg_idx;

  jtx_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(take_sample)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sref_s1_reg <= 1'b0;
      sref_s2_reg <= 1'b0;
      sref_d_reg <= 1'b0;
    end
    else
    begin
      sync_s1_reg <= link_sync_request_n_i;
      sync_s2_reg <= sync_s1_reg;
      sref_s1_reg <= system_timing_reference_i;
      sref_s2_reg <= sref_s1_reg;
      sref_d_reg <= sref_s2_reg;
    end
  end

  // Gated so a floating unused reference cannot disturb the boundary
  assign sref_edge = timing_ref_enable_i && sref_s2_reg && !sref_d_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Local multiframe clock: one octet slot per cycle
  assign frame_end = (oct_reg == octets_per_frame_m1_i);
  assign mf_end = frame_end && (frm_reg == frames_per_mf_m1_i);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || sref_edge)
    begin
      oct_reg <= '0;
      frm_reg <= '0;
      mpos_reg <= '0;
    end
    else
    begin
      oct_reg <= frame_end ? 8'h00 : oct_reg + 8'h01;
      mpos_reg <= mf_end ? 13'h0000 : mpos_reg + 13'h0001;
      if (frame_end)
      begin
        frm_reg <= mf_end ? 5'h00 : frm_reg + 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link state
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !sync_s2_reg)
    begin
      state_reg <= ST_CGS;
      mf_idx_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        ST_CGS:
          state_reg <= ST_WAIT;
        ST_WAIT:
          if (mf_end)
          begin
            state_reg <= ST_ILAS;
          end
        ST_ILAS:
          if (mf_end)
          begin
            mf_idx_reg <= mf_idx_reg + 2'h1;
            if (mf_idx_reg == ILAS_LAST_MF)
            begin
              state_reg <= ST_DATA;
            end
          end
        ST_DATA:
          state_reg <= ST_DATA;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || state_reg != ST_ILAS)
    begin
      ramp_reg <= '0;
    end
    else if (ramp_slot)
    begin
      ramp_reg <= ramp_reg + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration octets
  assign cfg_idx = 4'(mpos_reg - CFG_FIRST_POS);

  always_comb
  begin
    cfg[0] = DEV_ID;
    cfg[1] = {4'h0, BANK_ID};
    cfg[2] = {3'h0, lane_id_i};
    cfg[3] = {scramble_en_i, 2'h0, lanes_m1_i};
    cfg[4] = octets_per_frame_m1_i;
    cfg[5] = {3'h0, frames_per_mf_m1_i};
    cfg[6] = CFG_M_M1;
    cfg[7] = CFG_CS_N_M1;
    cfg[8] = {SUBCLASS, CFG_NP_M1};
    cfg[9] = CFG_JESDV_S_M1;
    cfg[10] = CFG_HD_CF;
    cfg[11] = CFG_RESERVED;
    cfg[12] = CFG_RESERVED;
    cfg[13] = '0;
    for (int i = 0; i < CFG_COUNT - 1; i++)
    begin
      cfg[13] = cfg[13] + cfg[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User data path
  assign take_sample = (state_reg == ST_DATA) && !lo_phase_reg;
  assign fmt_sample = fifo_data ^ (offset_binary_i ? FMT_FLIP : '0);
  assign raw_oct = lo_phase_reg ? lo_reg :
                   (fifo_valid ? fmt_sample[15:8] : OCT_IDLE);
  assign scr_word = scr8(raw_oct, scr_reg);
  assign data_oct = scramble_en_i ? scr_word[7:0] : raw_oct;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || state_reg != ST_DATA)
    begin
      lo_phase_reg <= 1'b0;
      lo_reg <= '0;
    end
    else
    begin
      lo_phase_reg <= !lo_phase_reg;
      if (!lo_phase_reg)
      begin
        lo_reg <= fifo_valid ? fmt_sample[7:0] : OCT_IDLE;
      end
    end
  end

  // Held during alignment so user data never sees alignment octets
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      scr_reg <= SCR_SEED;
    end
    else if (state_reg == ST_DATA && scramble_en_i)
    begin
      scr_reg <= scr_word[22:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      last_reg <= '0;
    end
    else if (state_reg == ST_DATA && frame_end)
    begin
      last_reg <= data_oct;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Octet selection
  always_comb
  begin
    oct_sel = OCT_K;
    k_sel = 1'b1;
    ramp_slot = 1'b0;
    unique case (state_reg)
      ST_CGS, ST_WAIT:
        ;
      ST_ILAS:
        if (mpos_reg == '0)
        begin
          oct_sel = OCT_R;
        end
        else if (mf_end)
        begin
          oct_sel = OCT_A;
        end
        else if (mf_idx_reg == ILAS_CFG_MF && mpos_reg == Q_POS)
        begin
          oct_sel = OCT_Q;
        end
        else if (mf_idx_reg == ILAS_CFG_MF && mpos_reg >= CFG_FIRST_POS &&
                 mpos_reg <= CFG_LAST_POS)
        begin
          oct_sel = cfg[cfg_idx];
          k_sel = 1'b0;
        end
        else
        begin
          oct_sel = ramp_reg;
          k_sel = 1'b0;
          ramp_slot = 1'b1;
        end
      ST_DATA:
      begin
        oct_sel = data_oct;
        k_sel = 1'b0;
        if (align_insert_en_i && frame_end)
        begin
          if (scramble_en_i)
          begin
            if (mf_end && data_oct == OCT_A)
            begin
              k_sel = 1'b1;
            end
            else if (!mf_end && data_oct == OCT_F)
            begin
              k_sel = 1'b1;
            end
          end
          else if (data_oct == last_reg)
          begin
            oct_sel = mf_end ? OCT_A : OCT_F;
            k_sel = 1'b1;
          end
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Encoder and lane output
  assign enc_word = enc(oct_sel, k_sel, rd_reg);

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_reg <= 1'b0;
      symbol_o <= '0;
      ilas_active_o <= 1'b0;
      user_data_o <= 1'b0;
    end
    else
    begin
      rd_reg <= enc_word[10];
      symbol_o <= lane_invert_i ? ~enc_word[9:0] : enc_word[9:0];
      ilas_active_o <= (state_reg == ST_ILAS);
      user_data_o <= (state_reg == ST_DATA);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_cgs_sends_k: assert property (
    state_reg == ST_CGS && !lane_invert_i |=>
      symbol_o == SYM_K_NEG || symbol_o == SYM_K_POS)
    else $error("K not sent while sync requested");
  a_ilas_on_boundary: assert property (
    $rose(state_reg == ST_ILAS) |-> oct_reg == '0 && frm_reg == '0)
    else $error("alignment not started on boundary");
  a_mf_opens_r: assert property (
    state_reg == ST_ILAS && mpos_reg == '0 && !lane_invert_i |=>
      symbol_o == SYM_R_NEG || symbol_o == SYM_R_POS)
    else $error("multiframe not opened with R");
  a_mf_closes_a: assert property (
    state_reg == ST_ILAS && mf_end && !lane_invert_i |=>
      symbol_o == SYM_A_NEG || symbol_o == SYM_A_POS)
    else $error("multiframe not closed with A");
  a_q_second: assert property (
    state_reg == ST_ILAS && mf_idx_reg == ILAS_CFG_MF &&
    mpos_reg == Q_POS && !mf_end && !lane_invert_i |=>
      symbol_o == SYM_Q_NEG || symbol_o == SYM_Q_POS)
    else $error("Q not in second slot");
  a_ramp_from_zero: assert property (
    $rose(state_reg == ST_ILAS) |-> ramp_reg == '0)
    else $error("ramp not starting at zero");
  a_data_after_four: assert property (
    state_reg == ST_ILAS && mf_end && mf_idx_reg == ILAS_LAST_MF &&
    sync_s2_reg |=> state_reg == ST_DATA && user_data_o == 1'b0 ##1
      user_data_o)
    else $error("user data not started after four multiframes");
  a_scr_held: assert property (
    state_reg != ST_DATA |=> $stable(scr_reg))
    else $error("scrambler advanced outside user data");
  a_f_insert: assert property (
    state_reg == ST_DATA && scramble_en_i && align_insert_en_i &&
    frame_end && !mf_end && data_oct == OCT_F && !lane_invert_i |=>
      symbol_o == SYM_F_NEG || symbol_o == SYM_F_POS)
    else $error("F not inserted");
  a_sync_drop: assert property (
    $fell(sync_s2_reg) |=> state_reg == ST_CGS)
    else $error("sync request ignored");

  c_reach_data: cover property (
    state_reg == ST_ILAS ##1 state_reg == ST_DATA);
  c_f_inserted: cover property (
    state_reg == ST_DATA && k_sel && oct_sel == OCT_F);
  c_a_inserted: cover property (
    state_reg == ST_DATA && k_sel && oct_sel == OCT_A);
  c_resync: cover property (state_reg == ST_DATA ##1 state_reg == ST_CGS);

endmodule // jtx_dll

`default_nettype wire

// file: core/jtx_pkg.sv
package jtx_pkg;

  localparam int SAMPLE_W = 16;
  localparam int FIFO_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Control octets, K28.y, and the idle data octet
  localparam logic [7:0] OCT_R = 8'h1C;
  localparam logic [7:0] OCT_A = 8'h7C;
  localparam logic [7:0] OCT_Q = 8'h9C;
  localparam logic [7:0] OCT_K = 8'hBC;
  localparam logic [7:0] OCT_F = 8'hFC;
  localparam logic [7:0] OCT_IDLE = 8'h00;

  // Encoded control symbols, abcdei fghj, a sent first
  localparam logic [9:0] SYM_R_NEG = 10'h0F4;
  localparam logic [9:0] SYM_R_POS = 10'h30B;
  localparam logic [9:0] SYM_A_NEG = 10'h0F3;
  localparam logic [9:0] SYM_A_POS = 10'h30C;
  localparam logic [9:0] SYM_Q_NEG = 10'h0F2;
  localparam logic [9:0] SYM_Q_POS = 10'h30D;
  localparam logic [9:0] SYM_K_NEG = 10'h0FA;
  localparam logic [9:0] SYM_K_POS = 10'h305;
  localparam logic [9:0] SYM_F_NEG = 10'h0F8;
  localparam logic [9:0] SYM_F_POS = 10'h307;

  // 8b/10b sub-block codes at negative disparity
  localparam logic [5:0] K28_6B = 6'h0F;
  localparam logic [3:0] ENC4_ALT = 4'h7;
  localparam logic [5:0] ENC6_NEG [0:31] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  localparam logic [3:0] ENC4_NEG [0:7] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

  ////////////////////////////////////////////////////////////////////////////
  // Alignment sequence layout
  localparam logic [1:0] ILAS_CFG_MF = 2'h1;
  localparam logic [1:0] ILAS_LAST_MF = 2'h3;
  localparam logic [12:0] Q_POS = 13'h0001;
  localparam logic [12:0] CFG_FIRST_POS = 13'h0002;
  localparam logic [12:0] CFG_LAST_POS = 13'h000F;
  localparam int CFG_COUNT = 14;
  localparam logic [7:0] CFG_M_M1 = 8'h01;
  localparam logic [7:0] CFG_CS_N_M1 = 8'h0F;
  localparam logic [4:0] CFG_NP_M1 = 5'h0F;
  localparam logic [7:0] CFG_JESDV_S_M1 = 8'h20;
  localparam logic [7:0] CFG_HD_CF = 8'h00;
  localparam logic [7:0] CFG_RESERVED = 8'h00;

  // Scrambler 1 + x^14 + x^15
  localparam int SCR_W = 15;
  localparam int SCR_TAP_A = 13;
  localparam int SCR_TAP_B = 14;
  localparam logic [14:0] SCR_SEED = 15'h7FFF;

  localparam logic [15:0] FMT_FLIP = 16'h8000;

  typedef enum logic [1:0] {ST_CGS, ST_WAIT, ST_ILAS, ST_DATA} jtx_state_type;

endpackage

// file: test/jtx_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Far-end receiver: holds the sync request low while told to, then lets
// it go only after three clean K symbols, as a real lock would
module jtx_rx_model import jtx_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [9:0] symbol_i,
  input wire logic invert_i,
  input wire logic hold_i,
  output logic link_sync_request_n_o
);
  logic [2:0] k_cnt_reg;
  logic [9:0] raw;

  // Undo lane inversion so K is seen in either leg order
  assign raw = invert_i ? ~symbol_i : symbol_i;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || hold_i)
    begin
      k_cnt_reg <= 3'h0;
      link_sync_request_n_o <= 1'b0;
    end
    else if (!link_sync_request_n_o)
    begin
      if (raw == SYM_K_NEG || raw == SYM_K_POS)
        k_cnt_reg <= k_cnt_reg + 3'h1;
      else
        k_cnt_reg <= 3'h0;
      link_sync_request_n_o <= (k_cnt_reg == 3'h3);
    end
  end
endmodule // jtx_rx_model

`default_nettype wire

// file: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench import jtx_pkg::*; ;
  // Arbitrary identity value
  localparam logic [7:0] DEV_ID_TB = 8'hA6;
  localparam int MF = 18;
  localparam logic [7:0] OPF_M1 = 8'h01;
  localparam logic [4:0] FPMF_M1 = 5'h08;
  localparam logic [4:0] LANE_ID = 5'h03;
  localparam logic [4:0] LANES_M1 = 5'h00;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] sample = 16'h0000;
  logic valid = 1'b0;
  logic scr = 1'b0;
  logic ins = 1'b1;
  logic inv = 1'b0;
  logic ob = 1'b0;
  logic hold = 1'b1;
  logic sync_n;
  logic ready;
  logic ilas;
  logic udata;
  logic [9:0] symbol;
  logic rd = 1'b0;
  logic [7:0] cfg [0:13];
  logic [15:0] q [$];
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  int first_start = -1;

  ////////////////////////////////////////////////////////////////////////////
  jtx_dll #(.DEV_ID(DEV_ID_TB), .BANK_ID(4'h0), .SUBCLASS(3'h1)) jtx_dll_inst (
    .clk_i(clk),
    .rst_n_i(rst_n),
    .sample_i(sample),
    .sample_valid_i(valid),
    .sample_ready_o(ready),
    .link_sync_request_n_i(sync_n),
    .system_timing_reference_i(1'b0),
    .timing_ref_enable_i(1'b0),
    .scramble_en_i(scr),
    .align_insert_en_i(ins),
    .lane_invert_i(inv),
    .offset_binary_i(ob),
    .lanes_m1_i(LANES_M1),
    .lane_id_i(LANE_ID),
    .octets_per_frame_m1_i(OPF_M1),
    .frames_per_mf_m1_i(FPMF_M1),
    .symbol_o(symbol),
    .ilas_active_o(ilas),
    .user_data_o(udata)
  );

  jtx_rx_model jtx_rx_model_inst (
    .clk_i(clk),
    .rst_n_i(rst_n),
    .symbol_i(symbol),
    .invert_i(inv),
    .hold_i(hold),
    .link_sync_request_n_o(sync_n)
  );

  initial
  begin
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line disparity: inversion keeps the ones count at 5 or not, so the
  // tracker needs no knowledge of the invert setting
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rst_n && symbol != 10'h000 && $countones(symbol) != 5)
      rd <= ~rd;
    if (cyc == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [9:0] enc(input logic [7:0] o, input logic k,
                                     input logic rd_i);
    logic [5:0] c6;
    logic [3:0] c4;
    logic r;
    logic [4:0] x;
    x = o[4:0];
    if (k)
    begin
      case (o)
        OCT_R: return rd_i ? SYM_R_POS : SYM_R_NEG;
        OCT_A: return rd_i ? SYM_A_POS : SYM_A_NEG;
        OCT_Q: return rd_i ? SYM_Q_POS : SYM_Q_NEG;
        OCT_K: return rd_i ? SYM_K_POS : SYM_K_NEG;
        default: return rd_i ? SYM_F_POS : SYM_F_NEG;
      endcase
    end
    c6 = ENC6_NEG[x];
    r = rd_i;
    if (r && ($countones(c6) != 3 || x == 5'h07))
      c6 = ~c6;
    if ($countones(c6) != 3)
      r = ~r;
    c4 = ENC4_NEG[o[7:5]];
    if (o[7:5] == 3'h7 && (r ? (x == 5'h0B || x == 5'h0D || x == 5'h0E)
                             : (x == 5'h11 || x == 5'h12 || x == 5'h14)))
      c4 = ENC4_ALT;
    if (r && ($countones(c4) != 2 || o[7:5] == 3'h3))
      c4 = ~c4;
    return {c6, c4};
  endfunction

  // Self-synchronising scrambler, MSB first; returns {state, octet}
  function automatic logic [22:0] scramble(input logic [7:0] d,
                                           input logic [14:0] st);
    logic [14:0] s;
    logic [7:0] o;
    s = st;
    for (int i = 7; i >= 0; i--)
    begin
      o[i] = d[i] ^ s[14] ^ s[13];
      s = {s[13:0], o[i]};
    end
    return {s, o};
  endfunction

  task automatic finish_test();
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %b", $time, what, got);
    end
  endtask

  task automatic chk_sym(input logic [7:0] o, input logic k,
                         input string what);
    logic [9:0] e;
    e = enc(o, k, rd);
    if (inv)
      e = ~e;
    total_checks++;
    if (symbol !== e)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, symbol, e);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Settings change only while the link sits in sync, never mid-frame
  task automatic run_link(input logic scr_v, input logic ob_v,
                          input logic inv_v, input logic ins_v,
                          input int nwords, input int nuser);
    int j;
    int s;
    int m;
    logic [7:0] ramp;
    logic [7:0] prev;
    logic [15:0] w;
    logic [14:0] st;
    logic [22:0] x;
    logic eop;
    hold = 1'b1;
    repeat (10) @(negedge clk);
    scr = scr_v;
    ob = ob_v;
    inv = inv_v;
    ins = ins_v;
    repeat (4) @(negedge clk);
    chk_bit(ilas, 1'b0, "alignment during sync");
    for (j = 0; j < 2; j++)
    begin
      chk_sym(OCT_K, 1'b1, "sync fill");
      @(negedge clk);
    end
    for (j = 0; j < nwords; j++)
    begin
      w = {8'h40 + 8'(j), 8'hE0 | 8'((j + 1) >> 1)};
      chk_bit(ready, 1'b1, "fifo space");
      valid = 1'b1;
      sample = w;
      q.push_back(w);
      @(negedge clk);
    end
    if (nwords == 16)
    begin
      chk_bit(ready, 1'b0, "fifo full");
      sample = 16'hDEAD;
      @(negedge clk);
      chk_bit(ready, 1'b0, "fifo refuses");
    end
    valid = 1'b0;
    repeat (12) @(negedge clk);
    hold = 1'b0;
    cfg = '{DEV_ID_TB, 8'h00, {3'h0, LANE_ID}, {scr_v, 2'h0, LANES_M1},
            OPF_M1, {3'h0, FPMF_M1}, 8'h01, 8'h0F, 8'h2F, 8'h20,
            8'h00, 8'h00, 8'h00, 8'h00};
    for (j = 0; j < 13; j++)
      cfg[13] = cfg[13] + cfg[j];
    for (j = 0; j < 300 && ilas !== 1'b1; j++)
      @(negedge clk);
    chk_bit(ilas, 1'b1, "alignment start");
    if (first_start < 0)
      first_start = cyc;
    else
      chk_bit((cyc - first_start) % MF == 0, 1'b1, "boundary");
    ramp = 8'h00;
    for (j = 0; j < 4 * MF; j++)
    begin
      s = j % MF;
      m = j / MF;
      chk_bit(ilas, 1'b1, "alignment length");
      if (s == 0)
        chk_sym(OCT_R, 1'b1, "mf start");
      else if (s == MF - 1)
        chk_sym(OCT_A, 1'b1, "mf end");
      else if (m == 1 && s == 1)
        chk_sym(OCT_Q, 1'b1, "cfg start");
      else if (m == 1 && s < 16)
        chk_sym(cfg[s - 2], 1'b0, "cfg octet");
      else
      begin
        chk_sym(ramp, 1'b0, "ramp");
        ramp = ramp + 8'h01;
      end
      @(negedge clk);
    end
    chk_bit(ilas, 1'b0, "alignment over");
    chk_bit(udata, 1'b1, "user data");
    prev = 8'h00;
    // Scrambler only runs in scrambled user data, so each run starts at seed
    st = SCR_SEED;
    for (j = 0; j < nuser; j++)
    begin
      if (j % 2 == 0)
      begin
        w = 16'h0000;
        if (q.size() > 0)
          w = q.pop_front() ^ (ob ? FMT_FLIP : 16'h0000);
      end
      x = scramble((j % 2 == 0) ? w[15:8] : w[7:0], st);
      st = x[22:8];
      eop = (j % MF == MF - 1);
      if (scr && ins && j % 2 == 1 && x[7:0] == (eop ? OCT_A : OCT_F))
        chk_sym(x[7:0], 1'b1, "scrambled insert");
      else if (scr)
        chk_sym(x[7:0], 1'b0, "scrambled octet");
      else if (j % 2 == 0)
        chk_sym(w[15:8], 1'b0, "high octet");
      else if (ins && w[7:0] == prev)
        chk_sym(eop ? OCT_A : OCT_F, 1'b1, "insert");
      else
        chk_sym(w[7:0], 1'b0, "low octet");
      if (j % 2 == 1)
        prev = w[7:0];
      @(negedge clk);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge clk);
    chk_bit(symbol === 10'h000, 1'b1, "symbol in reset");
    rst_n = 1'b1;
    @(negedge clk);
    chk_bit(ready, 1'b1, "ready after reset");
    chk_bit(ilas, 1'b0, "alignment after reset");
    chk_bit(udata, 1'b0, "data after reset");
    chk_sym(OCT_K, 1'b1, "symbol after reset");
    run_link(1'b0, 1'b0, 1'b0, 1'b1, 16, 40);
    run_link(1'b0, 1'b1, 1'b1, 1'b0, 16, 40);
    run_link(1'b1, 1'b0, 1'b0, 1'b1, 16, 40);
    finish_test();
  end
endmodule // testbench

`default_nettype wire
